// file: logic/capm_pkg.sv
// capm_pkg: shared constants and carriers for the core addressing and power-mode block.
// assumes a single core_clk domain; no register bus beyond the plain command port.
package capm_pkg;

   localparam int unsigned PC_W     = 14;
   localparam int unsigned RAM_AW   = 10;
   localparam int unsigned ROM_W    = 10;
   localparam int unsigned NIB_W    = 4;
   localparam int unsigned MREG_N   = 16;
   localparam int unsigned PAGE_LO  = 8;
   localparam int unsigned ZP_W     = 6;
   localparam int unsigned TBL_AFLAG_BIT = 8;
   localparam int unsigned TBL_PFLAG_BIT = 9;

   localparam logic [PC_W-1:0]  PC_RST      = 14'h0000;
   localparam logic [NIB_W-1:0] NIB_RST     = 4'h0;
   localparam logic [7:0]       PAGE_LAST   = 8'hff;
   localparam logic [RAM_AW-1:0] MREG_BASE  = 10'h020;

   // clock divide choices for the instruction clock
   localparam logic [1:0] DIV_SEL_16 = 2'h0;
   localparam logic [1:0] DIV_SEL_8  = 2'h1;
   localparam logic [1:0] DIV_SEL_4  = 2'h2;
   localparam int unsigned DIV_CNT_W = 4;

   typedef enum logic [3:0] {
      CAPM_OP_NOP,
      CAPM_OP_LONG_JUMP,
      CAPM_OP_LONG_GOTO_ALT,
      CAPM_OP_LONG_CALL,
      CAPM_OP_PAGE_JUMP,
      CAPM_OP_ZERO_CALL,
      CAPM_OP_TABLE_JUMP,
      CAPM_OP_TABLE_FETCH,
      CAPM_OP_MEM_IND,
      CAPM_OP_MEM_DIR,
      CAPM_OP_MEMREG_LOAD,
      CAPM_OP_MEMREG_SWAP,
      CAPM_OP_STANDBY,
      CAPM_OP_STOP
   } capm_op_t;

   typedef enum logic [1:0] {
      CAPM_RUN,
      CAPM_STANDBY,
      CAPM_STOPPED
   } capm_mode_t;

   // one decoded instruction as presented by the fetch/decode logic
   typedef struct packed {
      logic              valid;
      capm_op_t          op;
      logic [PC_W-1:0]   imm;
      logic              two_word;
   } capm_instr_t;

   // resulting ram access request
   typedef struct packed {
      logic              valid;
      logic [RAM_AW-1:0] addr;
      logic              memreg;
   } capm_ram_req_t;

endpackage

// file: logic/capm_core.sv
// capm_core: program counter, ram address forming, table fetch routing,
// instruction clock divider and the standby/stop sequencer of a 4-bit core.
// assumes the decoder presents one instruction per instruction-clock tick.
// Overview of operation
// - standby gates the execution clock; oscillator, interrupts and timer keep running
// - standby keeps registers, ram and pins exactly as before entry
// - reset pressed during standby gives a complete device reset
// - interrupt wake: taken if enable set, otherwise held pending and resume next
// - stop halts oscillator, execution, interrupts and timer
// - pins are high impedance in stop mode
// - ram survives stop recovery; working registers need not
// - reset from stop keeps ram; ordinary reset leaves working registers undefined
// - instruction clock is oscillator divided by 16, 8 or 4, fixed at build
// - indirect ram address is bank, column and digit pointer concatenated
// - direct ram access uses the full 10-bit second word as address
// - 16-digit memory-register area reached only by its load and swap ops
// - long jump, long goto and call load all 14 pc bits
// - 256-word pages; page jump replaces only low eight pc bits
// - page jump at last page word targets the following page
// - zero-page call loads six bits and clears pc bits 13 to 6
// - table jump target built from immediate, accumulator and auxiliary register
// - table fetch with bit 8 set writes data to accumulator and auxiliary
// - bit 9 set writes port registers; both bits write both at once
// - table fetch leaves pc to its normal sequential advance
// - interrupt enable clears on reset and inhibits all interrupts while low
`timescale 1ns/100ps
`default_nettype none

module capm_core #(
   parameter logic [1:0] DIV_SEL = capm_pkg::DIV_SEL_8
) (
   input  wire logic                                  core_clk,
   input  wire logic                                  rst_n,
   input  wire logic                                  stop_recover,
   input  wire capm_pkg::capm_instr_t                 instr,
   input  wire logic                                  irq_req,
   input  wire logic                                  irq_en_set,
   input  wire logic                                  irq_en_clr,
   input  wire logic [capm_pkg::ROM_W-1:0]            rom_word,
   input  wire logic [capm_pkg::NIB_W-1:0]            acc_wr_data,
   input  wire logic                                  acc_wr,
   input  wire logic [1:0]                            bank_in,
   input  wire logic [capm_pkg::NIB_W-1:0]            col_in,
   input  wire logic [capm_pkg::NIB_W-1:0]            digit_in,
   input  wire logic                                  ptr_wr,
   output logic [capm_pkg::PC_W-1:0]                  pc,
   output logic                                       instr_tick,
   output logic                                       timer_tick,
   output logic                                       osc_run,
   output logic                                       irq_take,
   output logic                                       irq_pending,
   output logic                                       irq_en,
   output logic [capm_pkg::NIB_W-1:0]                 acc,
   output logic [capm_pkg::NIB_W-1:0]                 aux,
   output logic [7:0]                                 table_out_port_lo_hi,
   output capm_pkg::capm_ram_req_t                    ram_req,
   output logic [capm_pkg::PC_W-1:0]                  table_addr,
   output logic                                       pins_hiz,
   output capm_pkg::capm_mode_t                       mode
);

   typedef struct packed {
      logic [capm_pkg::DIV_CNT_W-1:0] div_cnt;
      logic                           tick;
      capm_pkg::capm_mode_t           mode;
      logic [capm_pkg::PC_W-1:0]      pc;
      logic                           irq_en;
      logic                           irq_pend;
      logic                           irq_take;
      logic [capm_pkg::NIB_W-1:0]     acc;
      logic [capm_pkg::NIB_W-1:0]     aux;
      logic [1:0]                     bank;
      logic [capm_pkg::NIB_W-1:0]     col;
      logic [capm_pkg::NIB_W-1:0]     digit;
      logic [3:0]                     port_lo;
      logic [3:0]                     port_hi;
      capm_pkg::capm_ram_req_t        ram;
   } capm_state_t;

   capm_state_t s_q;
   capm_state_t s_d;
   logic        rst_int_n;
   // synchroniser kept apart from the state struct: it resets from the pin, the rest from it
   logic [1:0]  rst_sync_q;

   // divider terminal count for the build-time ratio
   function automatic logic [capm_pkg::DIV_CNT_W-1:0] div_last(input logic [1:0] sel);
      case (sel)
         capm_pkg::DIV_SEL_16: div_last = 4'hf;
         capm_pkg::DIV_SEL_4:  div_last = 4'h3;
         default:              div_last = 4'h7;
      endcase
   endfunction

   // target built from immediate, accumulator, auxiliary
   // immediate high, accumulator middle, auxiliary low
   function automatic logic [capm_pkg::PC_W-1:0] tbl_target(
      input logic [3:0] imm4,
      input logic [3:0] a,
      input logic [3:0] b
   );
      tbl_target = {2'h0, imm4, a, b};
   endfunction

   assign rst_int_n = rst_sync_q[1];

   always_comb begin
      logic [capm_pkg::PC_W-1:0] pc_seq;
      logic                      exec;
      pc_seq = '0;
      exec   = 1'b0;
      s_d    = s_q;
      s_d.irq_take = 1'b0;
      s_d.ram.valid = 1'b0;

      if (s_q.mode == capm_pkg::CAPM_STOPPED) begin
         s_d.tick = 1'b0;
      // fixed divide ratio for the instruction clock
      end else if (s_q.div_cnt == div_last(DIV_SEL)) begin
         s_d.div_cnt = '0;
         s_d.tick    = 1'b1;
      end else begin
         s_d.div_cnt = s_q.div_cnt + 4'h1;
         s_d.tick    = 1'b0;
      end

      if (irq_en_clr) begin
         s_d.irq_en = 1'b0;
      end else if (irq_en_set) begin
         s_d.irq_en = 1'b1;
      end

      // interrupt logic keeps sampling requests in standby
      if (irq_req && s_q.mode != capm_pkg::CAPM_STOPPED) begin
         s_d.irq_pend = 1'b1;
      end

      // execution only on ticks while running
      exec = s_q.tick && (s_q.mode == capm_pkg::CAPM_RUN);

      if (s_q.mode == capm_pkg::CAPM_STANDBY && s_q.tick && s_q.irq_pend) begin
         // wake; take it only if enabled, else stay pending
         s_d.mode = capm_pkg::CAPM_RUN;
         if (s_q.irq_en) begin
            s_d.irq_take = 1'b1;
            s_d.irq_pend = irq_req;
            s_d.irq_en   = 1'b0;
         end
      end else if (exec && s_q.irq_pend && s_q.irq_en) begin
         s_d.irq_take = 1'b1;
         s_d.irq_pend = irq_req;
         s_d.irq_en   = 1'b0;
      end else if (exec && instr.valid) begin
         // one per word, two for two-word instructions
         pc_seq = s_q.pc + (instr.two_word ? 14'h0002 : 14'h0001);
         s_d.pc = pc_seq;
         case (instr.op)
            capm_pkg::CAPM_OP_LONG_JUMP,
            capm_pkg::CAPM_OP_LONG_GOTO_ALT,
            capm_pkg::CAPM_OP_LONG_CALL: begin
               s_d.pc = instr.imm;
            end
            // low byte replaced; page taken from the advanced pc
            capm_pkg::CAPM_OP_PAGE_JUMP: begin
               s_d.pc = {pc_seq[capm_pkg::PC_W-1:capm_pkg::PAGE_LO], instr.imm[7:0]};
            end
            // six low bits, upper eight cleared
            capm_pkg::CAPM_OP_ZERO_CALL: begin
               s_d.pc = {8'h00, instr.imm[capm_pkg::ZP_W-1:0]};
            end
            capm_pkg::CAPM_OP_TABLE_JUMP: begin
               s_d.pc = tbl_target(instr.imm[3:0], s_q.acc, s_q.aux);
            end
            // pc only advances; route by flag bits
            capm_pkg::CAPM_OP_TABLE_FETCH: begin
               if (rom_word[capm_pkg::TBL_AFLAG_BIT]) begin
                  s_d.acc = rom_word[7:4];
                  s_d.aux = rom_word[3:0];
               end
               if (rom_word[capm_pkg::TBL_PFLAG_BIT]) begin
                  s_d.port_hi = rom_word[7:4];
                  s_d.port_lo = rom_word[3:0];
               end
            end
            capm_pkg::CAPM_OP_MEM_IND: begin
               s_d.ram = '{valid: 1'b1, addr: {s_q.bank, s_q.col, s_q.digit}, memreg: 1'b0};
            end
            // second word is the whole address
            capm_pkg::CAPM_OP_MEM_DIR: begin
               s_d.ram = '{valid: 1'b1, addr: instr.imm[capm_pkg::RAM_AW-1:0], memreg: 1'b0};
            end
            // memory-register window only through these two ops
            capm_pkg::CAPM_OP_MEMREG_LOAD,
            capm_pkg::CAPM_OP_MEMREG_SWAP: begin
               s_d.ram = '{valid: 1'b1,
                           addr: capm_pkg::MREG_BASE | {6'h00, instr.imm[3:0]},
                           memreg: 1'b1};
            end
            // entering standby touches no state but the mode and the sequential pc advance
            capm_pkg::CAPM_OP_STANDBY: begin
               s_d.mode = capm_pkg::CAPM_STANDBY;
            end
            capm_pkg::CAPM_OP_STOP: begin
               s_d.mode = capm_pkg::CAPM_STOPPED;
            end
            default: begin
            end
         endcase
      end

      if (exec && acc_wr) begin
         s_d.acc = acc_wr_data;
      end
      if (exec && ptr_wr) begin
         s_d.bank  = bank_in;
         s_d.col   = col_in;
         s_d.digit = digit_in;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   // any reset, including from standby, restores the full reset state
   // working registers get a value anyway; software must not rely on it
   always_ff @(posedge core_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         s_q.div_cnt  <= '0;
         s_q.tick     <= 1'b0;
         s_q.mode     <= capm_pkg::CAPM_RUN;
         s_q.pc       <= capm_pkg::PC_RST;
         s_q.irq_en   <= 1'b0;
         s_q.irq_pend <= 1'b0;
         s_q.irq_take <= 1'b0;
         s_q.acc      <= capm_pkg::NIB_RST;
         s_q.aux      <= capm_pkg::NIB_RST;
         s_q.bank     <= 2'h0;
         s_q.col      <= capm_pkg::NIB_RST;
         s_q.digit    <= capm_pkg::NIB_RST;
         s_q.port_lo  <= capm_pkg::NIB_RST;
         s_q.port_hi  <= capm_pkg::NIB_RST;
         s_q.ram      <= '0;
      end else begin
         s_q.div_cnt  <= s_d.div_cnt;
         s_q.tick     <= s_d.tick;
         s_q.mode     <= s_d.mode;
         s_q.pc       <= s_d.pc;
         s_q.irq_en   <= s_d.irq_en;
         s_q.irq_pend <= s_d.irq_pend;
         s_q.irq_take <= s_d.irq_take;
         s_q.acc      <= s_d.acc;
         s_q.aux      <= s_d.aux;
         s_q.bank     <= s_d.bank;
         s_q.col      <= s_d.col;
         s_q.digit    <= s_d.digit;
         s_q.port_lo  <= s_d.port_lo;
         s_q.port_hi  <= s_d.port_hi;
         s_q.ram      <= s_d.ram;
      end
   end

   assign pc                   = s_q.pc;
   assign instr_tick           = s_q.tick && (s_q.mode == capm_pkg::CAPM_RUN);
   // timer keeps its clock in standby
   assign timer_tick           = s_q.tick;
   assign osc_run              = (s_q.mode != capm_pkg::CAPM_STOPPED);
   assign irq_take             = s_q.irq_take;
   assign irq_pending          = s_q.irq_pend;
   assign irq_en               = s_q.irq_en;
   assign acc                  = s_q.acc;
   assign aux                  = s_q.aux;
   assign table_out_port_lo_hi = {s_q.port_hi, s_q.port_lo};
   assign ram_req              = s_q.ram;
   assign table_addr           = tbl_target(instr.imm[3:0], s_q.acc, s_q.aux);
   // pins released while stopped; ram itself lives outside and is untouched
   assign pins_hiz             = (s_q.mode == capm_pkg::CAPM_STOPPED) | stop_recover;
   assign mode                 = s_q.mode;

endmodule // capm_core

`default_nettype wire

// file: dv/capm_core_asserts.sv
// capm_core_asserts: port-level checks of the addressing and power-mode core.
// assumes one core_clk domain; rst_n low disables every check.
`timescale 1ns/100ps
`default_nettype none
module capm_core_asserts (
   input wire logic                      core_clk,
   input wire logic                      rst_n,
   input wire capm_pkg::capm_instr_t     instr,
   input wire logic [capm_pkg::PC_W-1:0] pc,
   input wire logic                      instr_tick,
   input wire logic                      timer_tick,
   input wire logic                      osc_run,
   input wire logic                      irq_take,
   input wire logic                      irq_en,
   input wire logic [3:0]                acc,
   input wire logic [3:0]                aux,
   input wire logic [7:0]                table_out_port_lo_hi,
   input wire capm_pkg::capm_ram_req_t   ram_req,
   input wire logic                      pins_hiz,
   input wire capm_pkg::capm_mode_t      mode
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic        ex;
   logic [13:0] pc_inc, pj_tgt, zc_tgt, tj_tgt;
   logic [9:0]  dir_a;
   assign ex     = instr_tick && instr.valid;
   assign pc_inc = pc + 14'h0001;
   assign pj_tgt = {pc_inc[13:8], instr.imm[7:0]};
   assign zc_tgt = {8'h00, instr.imm[5:0]};
   assign tj_tgt = {2'b00, instr.imm[3:0], acc, aux};
   assign dir_a  = instr.imm[9:0];
   a_stop_hiz: assert property (mode == capm_pkg::CAPM_STOPPED |-> pins_hiz)
      else $error("pins driven while stopped");
   a_stop_halt: assert property (mode == capm_pkg::CAPM_STOPPED |-> !osc_run && !instr_tick)
      else $error("clock or execution alive while stopped");
   a_stop_timer: assert property (mode == capm_pkg::CAPM_STOPPED [*2] |-> !timer_tick)
      else $error("timer ticks while stopped");
   a_sby_gate: assert property (mode == capm_pkg::CAPM_STANDBY |-> !instr_tick && osc_run)
      else $error("standby gating wrong");
   a_sby_hold: assert property (mode == capm_pkg::CAPM_STANDBY [*2]
      |-> $stable(pc) && $stable({acc, aux, table_out_port_lo_hi}))
      else $error("state moved in standby");
   a_irq_gate: assert property (irq_take |-> $past(irq_en))
      else $error("interrupt taken while disabled");
   a_table_jump: assert property (ex && instr.op == capm_pkg::CAPM_OP_TABLE_JUMP
      |=> irq_take || pc == $past(tj_tgt))
      else $error("table jump target wrong");
   a_page_jump: assert property (ex && instr.op == capm_pkg::CAPM_OP_PAGE_JUMP
      |=> irq_take || pc == $past(pj_tgt))
      else $error("page jump target wrong");
   a_zero_call: assert property (ex && instr.op == capm_pkg::CAPM_OP_ZERO_CALL
      |=> irq_take || pc == $past(zc_tgt))
      else $error("zero page call target wrong");
   a_long_jump: assert property (ex && instr.op inside {capm_pkg::CAPM_OP_LONG_JUMP,
      capm_pkg::CAPM_OP_LONG_GOTO_ALT, capm_pkg::CAPM_OP_LONG_CALL}
      |=> irq_take || pc == $past(instr.imm))
      else $error("long branch target wrong");
   a_dir_addr: assert property (ex && instr.op == capm_pkg::CAPM_OP_MEM_DIR
      |=> irq_take || (ram_req.valid && !ram_req.memreg && ram_req.addr == $past(dir_a)))
      else $error("direct ram address wrong");
   a_memreg_area: assert property (ex && instr.op inside {capm_pkg::CAPM_OP_MEMREG_LOAD,
      capm_pkg::CAPM_OP_MEMREG_SWAP}
      |=> irq_take || (ram_req.valid && ram_req.memreg && ram_req.addr[9:4] == 6'h02))
      else $error("memory register access wrong");
   c_wake: cover property (mode == capm_pkg::CAPM_STANDBY ##1 irq_take);
   c_stop: cover property (mode == capm_pkg::CAPM_STOPPED);
   c_edge: cover property (ex && instr.op == capm_pkg::CAPM_OP_PAGE_JUMP && pc[7:0] == 8'hff);
endmodule // capm_core_asserts
bind capm_core capm_core_asserts i_capm_core_asserts (.core_clk, .rst_n, .instr, .pc,
   .instr_tick, .timer_tick, .osc_run, .irq_take, .irq_en, .acc, .aux,
   .table_out_port_lo_hi, .ram_req, .pins_hiz, .mode);
`default_nettype wire

// file: dv/capm_far_model.sv
// capm_far_model: stands in for the reset pin and the interrupt request source.
// assumes the bench calls its tasks; lines move just after a core_clk edge.
`timescale 1ns/100ps
`default_nettype none
module capm_far_model (
   input  wire logic core_clk,
   output logic      rst_n,
   output logic      stop_recover,
   output logic      irq_req
);
   initial begin
      rst_n        = 1'b0;
      stop_recover = 1'b0;
      irq_req      = 1'b0;
   end
   // reset hold length
   // caller passes the settle time after stop, at least ten cycles otherwise
   task automatic hold_reset(input int cyc, input logic from_stop);
      @(posedge core_clk);
      rst_n        <= 1'b0;
      stop_recover <= from_stop;
      repeat (cyc) @(posedge core_clk);
      rst_n        <= 1'b1;
      stop_recover <= 1'b0;
   endtask
   task automatic set_irq(input logic lvl);
      @(posedge core_clk);
      irq_req <= lvl;
   endtask
endmodule // capm_far_model
`default_nettype wire

// file: dv/tb_core_addressing_power_modes.sv
// tb_core_addressing_power_modes: branches, table fetch, ram modes, standby and stop.
// assumes capm_far_model supplies reset and interrupt request; divide by 8.
`timescale 1ns/100ps
`default_nettype none
module tb_core_addressing_power_modes;
   logic                    core_clk, rst_n, stop_recover, irq_req, irq_en_set, irq_en_clr;
   logic                    acc_wr, ptr_wr, instr_tick, timer_tick, osc_run, irq_take;
   logic                    irq_pending, irq_en, pins_hiz;
   logic [1:0]              bank_in;
   logic [3:0]              acc_wr_data, col_in, digit_in, acc, aux;
   logic [7:0]              table_out_port_lo_hi;
   logic [9:0]              rom_word;
   logic [13:0]             pc, table_addr;
   logic [31:0]             seed = 32'h2d86_0794;
   capm_pkg::capm_instr_t   instr;
   capm_pkg::capm_ram_req_t ram_req;
   capm_pkg::capm_mode_t    mode;
   int                      err_total, n_compared, m_pc, m_acc, m_aux, m_port, m_ptr;
   capm_core i_capm_core (.core_clk, .rst_n, .stop_recover, .instr, .irq_req, .irq_en_set,
      .irq_en_clr, .rom_word, .acc_wr_data, .acc_wr, .bank_in, .col_in, .digit_in, .ptr_wr,
      .pc, .instr_tick, .timer_tick, .osc_run, .irq_take, .irq_pending, .irq_en, .acc, .aux,
      .table_out_port_lo_hi, .ram_req, .table_addr, .pins_hiz, .mode);
   capm_far_model i_capm_far_model (.core_clk, .rst_n, .stop_recover, .irq_req);
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // issue one instruction, hold it until a tick takes it, then update the model
   task automatic run_op(input capm_pkg::capm_op_t op, input logic [13:0] imm,
                         input logic wa, input logic wp);
      int          npc, n;
      logic        t, tw;
      logic [11:0] er;
      tw  = (op == capm_pkg::CAPM_OP_MEM_DIR);
      npc = (m_pc + (tw ? 2 : 1)) % 16384;
      @(posedge core_clk);
      instr  <= '{1'b1, op, imm, tw};
      acc_wr <= wa;
      ptr_wr <= wp;
      t = 1'b0;
      for (n = 0; n < 40 && !t; n++) begin
         #1 t = instr_tick;
         @(posedge core_clk);
      end
      instr  <= '0;
      acc_wr <= 1'b0;
      ptr_wr <= 1'b0;
      #1;
      case (op)
         capm_pkg::CAPM_OP_LONG_JUMP, capm_pkg::CAPM_OP_LONG_GOTO_ALT,
         capm_pkg::CAPM_OP_LONG_CALL:  m_pc = imm;
         capm_pkg::CAPM_OP_PAGE_JUMP:  m_pc = npc / 256 * 256 + imm[7:0];
         capm_pkg::CAPM_OP_ZERO_CALL:  m_pc = imm[5:0];
         capm_pkg::CAPM_OP_TABLE_JUMP: m_pc = imm[3:0] * 256 + m_acc * 16 + m_aux;
         default:                      m_pc = npc;
      endcase
      if (wa) m_acc = acc_wr_data;
      if (wp) m_ptr = {bank_in, col_in, digit_in};
      if (op == capm_pkg::CAPM_OP_TABLE_FETCH && rom_word[8]) begin
         m_acc = rom_word[7:4];
         m_aux = rom_word[3:0];
      end
      if (op == capm_pkg::CAPM_OP_TABLE_FETCH && rom_word[9]) m_port = rom_word[7:0];
      case (op)
         capm_pkg::CAPM_OP_MEM_IND:    er = {1'b1, m_ptr[9:0], 1'b0};
         capm_pkg::CAPM_OP_MEM_DIR:    er = {1'b1, imm[9:0], 1'b0};
         capm_pkg::CAPM_OP_MEMREG_LOAD,
         capm_pkg::CAPM_OP_MEMREG_SWAP: er = {1'b1, 6'h02, imm[3:0], 1'b1};
         default:                      er = '0;
      endcase
      chk(t, 1);
      chk(pc, m_pc);
      chk({acc, aux, table_out_port_lo_hi}, m_acc * 4096 + m_aux * 256 + m_port);
      chk(er[11] ? 12'(ram_req) : 12'(ram_req.valid), er);
      chk(table_addr, m_acc * 16 + m_aux);
   endtask
   // wait in standby, raise the request and see whether it is taken
   task automatic sby_wake(input logic en);
      int   n, tk;
      logic took;
      tk   = 0;
      took = 1'b0;
      chk(mode, capm_pkg::CAPM_STANDBY);
      for (n = 0; n < 40; n++) begin
         @(posedge core_clk);
         #1 tk += timer_tick;
      end
      chk(tk != 0, 1);
      chk(pc, m_pc);
      // one-cycle request: a taken interrupt then leaves nothing pending behind
      i_capm_far_model.set_irq(1'b1);
      i_capm_far_model.set_irq(1'b0);
      for (n = 0; n < 60; n++) begin
         @(posedge core_clk);
         #1 took |= irq_take;
      end
      chk({mode, took}, {capm_pkg::CAPM_RUN, en});
      chk(irq_pending, !en);
   endtask
   initial begin
      logic [31:0]         r;
      time                 t0;
      capm_pkg::capm_op_t  op;
      instr = '0;
      {irq_en_set, irq_en_clr, acc_wr, ptr_wr, rom_word, acc_wr_data, bank_in, col_in,
         digit_in} = '0;
      i_capm_far_model.hold_reset(10, 1'b0);
      repeat (3) @(posedge core_clk);
      chk(irq_en, 0);
      run_op(capm_pkg::CAPM_OP_NOP, 14'h0000, 1'b0, 1'b0);
      t0 = $time;
      run_op(capm_pkg::CAPM_OP_NOP, 14'h0000, 1'b0, 1'b0);
      chk(32'($time - t0), 40);
      for (int i = 0; i < 60; i++) begin
         r  = rnd();
         op = capm_pkg::capm_op_t'(r % 12);
         {rom_word, acc_wr_data, bank_in, col_in, digit_in} <= r[31:8];
         run_op(op, 14'(rnd()), op == capm_pkg::CAPM_OP_NOP && r[0],
                op == capm_pkg::CAPM_OP_NOP && r[1]);
      end
      for (int k = 0; k < 4; k++) begin
         run_op(capm_pkg::CAPM_OP_LONG_JUMP, {k[5:0], 8'hff}, 1'b0, 1'b0);
         run_op(capm_pkg::CAPM_OP_PAGE_JUMP, {8'h00, k[5:0]}, 1'b0, 1'b0);
         rom_word <= {k[1:0], 8'h5a ^ k[7:0]};
         run_op(capm_pkg::CAPM_OP_TABLE_FETCH, 14'h0000, 1'b0, 1'b0);
         run_op(capm_pkg::CAPM_OP_TABLE_JUMP, {10'h000, k[3:0]}, 1'b0, 1'b0);
      end
      for (int e = 1; e >= 0; e--) begin
         {irq_en_set, irq_en_clr} <= {e[0], !e[0]};
         @(posedge core_clk);
         {irq_en_set, irq_en_clr} <= 2'b00;
         run_op(capm_pkg::CAPM_OP_STANDBY, 14'h0000, 1'b0, 1'b0);
         sby_wake(e[0]);
         if (e[0]) run_op(capm_pkg::CAPM_OP_LONG_JUMP, 14'h0100, 1'b0, 1'b0);
      end
      run_op(capm_pkg::CAPM_OP_NOP, 14'h0000, 1'b0, 1'b0);
      // re-enabling lets the held request through at the next tick, so standby below stays put
      {irq_en_set, irq_en_clr} <= 2'b10;
      @(posedge core_clk);
      {irq_en_set, irq_en_clr} <= 2'b00;
      repeat (10) @(posedge core_clk);
      #1 chk({irq_pending, irq_en}, 2'b00);
      for (int s = 0; s < 2; s++) begin
         run_op(s ? capm_pkg::CAPM_OP_STOP : capm_pkg::CAPM_OP_STANDBY, 14'h0000, 1'b0, 1'b0);
         repeat (20) @(posedge core_clk);
         #1;
         if (s) begin
            chk({pins_hiz, osc_run, instr_tick}, 3'b100);
            chk(mode, capm_pkg::CAPM_STOPPED);
         end else begin
            chk(mode, capm_pkg::CAPM_STANDBY);
         end
         chk(pc, m_pc);
         i_capm_far_model.hold_reset(s ? 64 : 20, s[0]);
         repeat (3) @(posedge core_clk);
         {m_pc, m_acc, m_aux, m_port, m_ptr} = '0;
         run_op(capm_pkg::CAPM_OP_NOP, 14'h0000, 1'b0, 1'b0);
      end
      conclude();
   end
   initial begin
      #200_000;
      err_total++;
      conclude();
   end
endmodule // tb_core_addressing_power_modes
`default_nettype wire
